/* File: operational_state_control.sv */
// operational-state register bank: state selector, start/stop, power-down, soft reset
`timescale 1ns/1ps
module operational_state_control
(
    // clock and reset
    input  wire logic                   CLOCK_IN,
    input  wire logic                   RESET_N_IN,
    input  wire logic                   CLK_EN_IN,
    // register access from the serial host interface logic
    input  wire opstate_pkg::reg_req_t  REQ_IN,
    output opstate_pkg::reg_rsp_t       RSP_OUT,
    // converter handshake
    input  wire logic                   CONV_DONE_IN,
    output logic                        CONV_RUN_OUT,
    output logic                        READY_OUT,
    // power and control outputs
    output logic                        POWER_DOWN_ACTIVE_OUT,
    output logic                        STARTUP_OVERRIDE_OUT,
    output logic                        CLEAR_RESULTS_OUT,
    output logic                        CONTROL_RESET_OUT,
    output logic                        MEASURING_OUT
);
    // operational states, one-hot
    typedef enum logic [1:0] {
        ST_CONFIG  = 2'b01,
        ST_MEASURE = 2'b10
    } op_state_t;

    op_state_t  state_ff;
    op_state_t  nxt_state;
    logic       start_ff;
    logic       pd_ff;
    logic       conv_ff;
    logic       pd_active_ff;
    logic       override_ff;
    logic       clear_ff;
    logic       sreset_ff;
    logic       done_meta_ff;
    logic       done_sync_ff;
    logic [7:0] rdata_ff;
    logic       refused_ff;
    logic       result_sel_ff;

    logic       is_state;
    logic       is_gen_id;
    logic       is_result;
    logic       refused;
    logic       state_wr;
    logic       sreset_wr;
    logic [2:0] sel_wr;
    logic       enter_config;
    logic       measuring;

    assign measuring = (state_ff == ST_MEASURE);

    // address classification, shared with nothing else
    opstate_decode u_decode
    (
        .addr_in       (REQ_IN.addr),
        .measuring_in  (measuring),
        .is_state_out  (is_state),
        .is_gen_id_out (is_gen_id),
        .is_result_out (is_result),
        .refused_out   (refused)
    );

    // selector code read back from the present state only [RQ2]
    function automatic logic [2:0] sel_code(input op_state_t st);
        sel_code = (st == ST_MEASURE) ? opstate_pkg::SEL_MEASURE : opstate_pkg::SEL_CONFIG;
    endfunction

    // write strobes for the state register
    assign state_wr  = REQ_IN.wr && is_state;
    assign sreset_wr = state_wr && REQ_IN.wdata[opstate_pkg::BIT_SOFT_RESET]; // [RQ7]
    assign sel_wr    = REQ_IN.wdata[opstate_pkg::SEL_MSB:0];

    // next state: only soft reset, 010 and 011 move it, other codes are no-ops [RQ1] [RQ6]
    always_comb
    begin
        nxt_state = state_ff;
        if (sreset_wr)
        begin
            nxt_state = ST_CONFIG; // [RQ7]
        end
        else if (state_wr)
        begin
            case (sel_wr)
                opstate_pkg::SEL_CONFIG:  nxt_state = ST_CONFIG;  // [RQ1]
                opstate_pkg::SEL_MEASURE: nxt_state = ST_MEASURE; // [RQ1]
                default:                  nxt_state = state_ff;   // [RQ6]
            endcase
        end
    end

    // leaving measurement, or soft reset, drops start and clears results [RQ5]
    assign enter_config = sreset_wr || (measuring && nxt_state == ST_CONFIG);

    // operational state register, resets to configuration [RQ15]
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            state_ff <= ST_CONFIG;
        end
        else if (CLK_EN_IN)
        begin
            state_ff <= nxt_state;
        end
    end

    // start/stop bit; only taken when the write leaves us in measurement [RQ9] [RQ17]
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            start_ff <= opstate_pkg::OPSTATE_RESET[opstate_pkg::BIT_START_STOP]; // [RQ10]
        end
        else if (CLK_EN_IN)
        begin
            if (enter_config)
            begin
                start_ff <= 1'b0; // [RQ10]
            end
            else if (state_wr && nxt_state == ST_MEASURE)
            begin
                start_ff <= REQ_IN.wdata[opstate_pkg::BIT_START_STOP]; // [RQ16] [RQ9]
            end
            else if (state_wr)
            begin
                start_ff <= 1'b0; // written while in configuration: ignored as zero [RQ9]
            end
        end
    end

    // power-down bit, written in both states, even with a no-op selector [RQ11] [RQ6]
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            pd_ff <= opstate_pkg::OPSTATE_RESET[opstate_pkg::BIT_POWER_DOWN];
        end
        else if (CLK_EN_IN)
        begin
            if (sreset_wr)
            begin
                pd_ff <= opstate_pkg::OPSTATE_RESET[opstate_pkg::BIT_POWER_DOWN]; // [RQ11]
            end
            else if (state_wr)
            begin
                pd_ff <= REQ_IN.wdata[opstate_pkg::BIT_POWER_DOWN]; // [RQ11]
            end
        end
    end

    // conversion done pin crosses into our clock through two flops
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            done_meta_ff <= 1'b0;
            done_sync_ff <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            done_meta_ff <= CONV_DONE_IN;
            done_sync_ff <= done_meta_ff;
        end
    end

    // conversion tracking: starts on start bit in measurement, stops at once on leave
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            conv_ff <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            if (enter_config || !measuring)
            begin
                conv_ff <= 1'b0; // [RQ5] [RQ7] [RQ3]
            end
            else if (conv_ff && done_sync_ff)
            begin
                conv_ff <= 1'b0; // end of conversion [RQ20]
            end
            else if (!conv_ff && start_ff && !done_sync_ff)
            begin
                conv_ff <= 1'b1; // [RQ9] [RQ20]
            end
        end
    end

    // internal start-up: start with power-down set overrides it while converting
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            override_ff <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            if (enter_config)
            begin
                override_ff <= 1'b0;
            end
            else if (state_wr && nxt_state == ST_MEASURE)
            begin
                override_ff <= REQ_IN.wdata[opstate_pkg::BIT_START_STOP]
                               && REQ_IN.wdata[opstate_pkg::BIT_POWER_DOWN]; // [RQ13]
            end
        end
    end

    // power-down applied freely in configuration, only in pauses in measurement;
    // a request during a conversion simply waits for conv_ff to fall [RQ12] [RQ22]
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            pd_active_ff <= 1'b1;
        end
        else if (CLK_EN_IN)
        begin
            if (!measuring)
            begin
                pd_active_ff <= pd_ff; // [RQ11]
            end
            else
            begin
                pd_active_ff <= pd_ff && !conv_ff; // [RQ12] [RQ22]
            end
        end
    end

    // one-cycle pulses: clear results on leaving measurement, reset control bank
    // self-clearing so a single write gives a single reset [RQ21]
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            clear_ff  <= 1'b0;
            sreset_ff <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            clear_ff  <= enter_config;  // [RQ5]
            sreset_ff <= sreset_wr;     // [RQ7] [RQ21]
        end
    end

    // read data and refusal, registered one cycle after the request
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            rdata_ff      <= 8'h00;
            refused_ff    <= 1'b0;
            result_sel_ff <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            refused_ff    <= (REQ_IN.rd || REQ_IN.wr) && refused; // [RQ4]
            result_sel_ff <= REQ_IN.rd && is_result;               // [RQ4]
            rdata_ff      <= 8'h00;
            if (REQ_IN.rd && is_state)
            begin
                // reserved 5:4 and soft reset bit read zero [RQ14] [RQ8]
                rdata_ff <= {start_ff, pd_ff, 2'b00, 1'b0, sel_code(state_ff)}; // [RQ2]
            end
            else if (REQ_IN.rd && is_gen_id)
            begin
                // read-only; writes fall through with no effect [RQ18]
                rdata_ff <= {opstate_pkg::DEVICE_ID_VALUE, opstate_pkg::BANK_REV_VALUE};
            end
        end
    end

    // outputs
    assign RSP_OUT.rdata          = rdata_ff;
    assign RSP_OUT.refused        = refused_ff;
    assign RSP_OUT.result_sel     = result_sel_ff;
    assign CONV_RUN_OUT           = conv_ff;
    assign READY_OUT              = !conv_ff;  // low while converting [RQ20]
    assign POWER_DOWN_ACTIVE_OUT  = pd_active_ff;
    assign STARTUP_OVERRIDE_OUT   = override_ff && conv_ff; // [RQ13]
    assign CLEAR_RESULTS_OUT      = clear_ff;
    assign CONTROL_RESET_OUT      = sreset_ff;
    assign MEASURING_OUT          = measuring;
endmodule

/* File: opstate_pkg.sv */
// package: register map, field layout, codes and types of the operational-state block
//
// How it works
// [RQ1] selector write 010 enters configuration, 011 measurement; 00X and 1XX keep state
// [RQ2] state register read returns 010 or 011 in the selector bits
// [RQ3] configuration state allows control bank access and runs no measurement
// [RQ4] results readable only in measurement; other control registers refused there
// [RQ5] back to configuration keeps controls, clears results, stops measurement at once
// [RQ6] no-operation selector keeps state but other written bits still take effect
// [RQ7] soft reset bit 3 stops measurement, enters configuration, resets all registers
// [RQ8] soft reset acts only on write; reads return zero
// [RQ9] start bit 7 starts on one, stops on zero, only in measurement state
// [RQ10] start bit clears after power-on reset, soft reset, entering configuration
// [RQ11] power-down bit 6 acts in both states, defaults to one
// [RQ12] in measurement, power-down applies only in pauses between conversions
// [RQ13] start with power-down set starts measurement with internal start-up override
// [RQ14] reserved bits 5 and 4 read zero; host should write zero
// [RQ15] selector resets to configuration code; state register resets to 42h
// [RQ16] write 83h enters measurement and starts with power-down off
// [RQ17] write 80h starts measurement only if measurement state already active
// [RQ18] generation id is read-only: identifier upper nibble, revision lower nibble
// [RQ19] upper four bits of the register address are ignored
// [RQ20] ready goes low at conversion start, high at conversion end
// [RQ21] soft reset self-clears within one clock after the write
// [RQ22] power-down raised during a conversion waits for the next pause
package opstate_pkg;

    // register indices within the low address nibble
    localparam logic [3:0] ADDR_OPERATIONAL_STATE = 4'h0;
    localparam logic [3:0] ADDR_REGISTER_GEN_ID   = 4'h2;
    localparam logic [3:0] ADDR_RESULT_FIRST      = 4'h1;
    localparam logic [3:0] ADDR_RESULT_LAST       = 4'h6;
    localparam int         ADDR_LOW_BITS          = 4;

    // field positions of the state register
    localparam int BIT_START_STOP = 7;
    localparam int BIT_POWER_DOWN = 6;
    localparam int BIT_SOFT_RESET = 3;
    localparam int SEL_MSB        = 2;

    // state selector codes
    localparam logic [2:0] SEL_CONFIG  = 3'h2;
    localparam logic [2:0] SEL_MEASURE = 3'h3;

    // reset value of the state register and the id fields (id values arbitrary)
    localparam logic [7:0] OPSTATE_RESET   = 8'h42;
    localparam logic [3:0] DEVICE_ID_VALUE = 4'h5;
    localparam logic [3:0] BANK_REV_VALUE  = 4'h3;

    // register bus request carried from the host side logic
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // answer to the host side logic
    typedef struct packed {
        logic       refused;
        logic       result_sel;
        logic [7:0] rdata;
    } reg_rsp_t;

endpackage

/* File: opstate_decode.sv */
// decode of a host register address into access class for the current state
`timescale 1ns/1ps
module opstate_decode
(
    // request and state
    input  wire logic [7:0] addr_in,
    input  wire logic       measuring_in,
    // decoded class
    output logic            is_state_out,
    output logic            is_gen_id_out,
    output logic            is_result_out,
    output logic            refused_out
);
    logic [3:0] low_addr;

    // upper nibble dropped before any compare [RQ19]
    assign low_addr      = addr_in[opstate_pkg::ADDR_LOW_BITS-1:0];
    assign is_state_out  = (low_addr == opstate_pkg::ADDR_OPERATIONAL_STATE);
    assign is_result_out = measuring_in
                           && (low_addr >= opstate_pkg::ADDR_RESULT_FIRST)
                           && (low_addr <= opstate_pkg::ADDR_RESULT_LAST); // [RQ4]
    assign is_gen_id_out = !measuring_in && (low_addr == opstate_pkg::ADDR_REGISTER_GEN_ID);

    // in measurement only the state register and results answer [RQ4] [RQ3]
    assign refused_out = measuring_in && !is_state_out && !is_result_out;
endmodule

/* File: conv_model.sv */
// behavioural converter answering the conversion run request
`timescale 1ns/1ps
module conv_model
#(
    parameter int CONV_CYCLES = 6
)
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // conversion handshake
    input  wire logic run_in,
    input  wire logic slow_in,
    output logic      done_out
);
    logic [7:0] count_ff;
    logic       done_ff;

    // done is a level held until run drops, so the block sees a true end of conversion
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_ff <= 8'h00;
            done_ff  <= 1'b0;
        end
        else if (!run_in)
        begin
            count_ff <= 8'h00;
            done_ff  <= 1'b0;
        end
        else if (count_ff == 8'(slow_in ? CONV_CYCLES * 4 : CONV_CYCLES))
            done_ff <= 1'b1;
        else
            count_ff <= count_ff + 8'h01;
    end

    assign done_out = done_ff;
endmodule

/* File: operational_state_control_checker.sv */
// port-level assertions of the operational-state register bank
`timescale 1ns/1ps
module operational_state_control_checker
(
    // clock and reset
    input wire logic                  CLOCK_IN,
    input wire logic                  RESET_N_IN,
    input wire logic                  CLK_EN_IN,
    // register access
    input wire opstate_pkg::reg_req_t REQ_IN,
    input wire opstate_pkg::reg_rsp_t RSP_OUT,
    // converter, power and control
    input wire logic                  CONV_DONE_IN,
    input wire logic                  CONV_RUN_OUT,
    input wire logic                  READY_OUT,
    input wire logic                  POWER_DOWN_ACTIVE_OUT,
    input wire logic                  STARTUP_OVERRIDE_OUT,
    input wire logic                  CLEAR_RESULTS_OUT,
    input wire logic                  CONTROL_RESET_OUT,
    input wire logic                  MEASURING_OUT
);
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    // requests taken at this edge; only the low address nibble decodes
    wire take_wr = CLK_EN_IN && REQ_IN.wr && REQ_IN.addr[3:0] == 4'h0;
    wire take_rd = CLK_EN_IN && REQ_IN.rd && !REQ_IN.wr && REQ_IN.addr[3:0] == 4'h0;
    wire take_any = CLK_EN_IN && (REQ_IN.wr || REQ_IN.rd);

    // leaving measurement: state and conversion drop together
    sequence leave_s;
        take_wr && MEASURING_OUT && REQ_IN.wdata[3:0] == 4'h2 ##1 !CONV_RUN_OUT && !MEASURING_OUT;
    endsequence

    state_sel_a: assert property (take_wr && !REQ_IN.wdata[3] && REQ_IN.wdata[2:1] == 2'b01
        |=> MEASURING_OUT == $past(REQ_IN.wdata[0])) else $error("selector write lost");
    nop_keep_a: assert property (take_wr && !REQ_IN.wdata[3] && REQ_IN.wdata[2:1] != 2'b01
        |=> $stable(MEASURING_OUT)) else $error("nop code changed state");
    state_read_a: assert property (take_rd
        |=> RSP_OUT.rdata[5:0] == {3'b000, 2'b01, MEASURING_OUT}) else $error("state read bad");
    gen_id_a: assert property (take_any && REQ_IN.rd && REQ_IN.addr[3:0] == 4'h2 && !MEASURING_OUT
        |=> RSP_OUT.rdata == {opstate_pkg::DEVICE_ID_VALUE, opstate_pkg::BANK_REV_VALUE})
        else $error("id read bad");
    refuse_a: assert property (take_any && MEASURING_OUT && REQ_IN.addr[3:0] > 4'h6
        |=> RSP_OUT.refused) else $error("control access not refused");
    config_open_a: assert property (take_any && !MEASURING_OUT |=> !RSP_OUT.refused)
        else $error("refused in configuration");
    no_conv_cfg_a: assert property (!MEASURING_OUT |-> !CONV_RUN_OUT)
        else $error("conversion outside measurement");
    leave_clear_a: assert property (leave_s |-> ##[0:1] CLEAR_RESULTS_OUT)
        else $error("results not cleared");
    soft_reset_a: assert property (take_wr && REQ_IN.wdata[3]
        |=> CONTROL_RESET_OUT && !MEASURING_OUT && !CONV_RUN_OUT ##1 !CONTROL_RESET_OUT)
        else $error("soft reset bad");
    ready_inv_a: assert property (READY_OUT != CONV_RUN_OUT)
        else $error("ready not inverse of run");
    pd_conv_a: assert property (CONV_RUN_OUT && $past(CONV_RUN_OUT) |-> !POWER_DOWN_ACTIVE_OUT)
        else $error("power down in conversion");
    override_a: assert property (STARTUP_OVERRIDE_OUT |-> CONV_RUN_OUT)
        else $error("override outside conversion");
endmodule

bind operational_state_control operational_state_control_checker chk_i (.CLOCK_IN(CLOCK_IN),
    .RESET_N_IN(RESET_N_IN), .CLK_EN_IN(CLK_EN_IN), .REQ_IN(REQ_IN), .RSP_OUT(RSP_OUT),
    .CONV_DONE_IN(CONV_DONE_IN), .CONV_RUN_OUT(CONV_RUN_OUT), .READY_OUT(READY_OUT),
    .POWER_DOWN_ACTIVE_OUT(POWER_DOWN_ACTIVE_OUT), .STARTUP_OVERRIDE_OUT(STARTUP_OVERRIDE_OUT),
    .CLEAR_RESULTS_OUT(CLEAR_RESULTS_OUT), .CONTROL_RESET_OUT(CONTROL_RESET_OUT),
    .MEASURING_OUT(MEASURING_OUT));

/* File: operational_state_control_test.sv */
// self-checking bench of the operational-state register bank
`timescale 1ns/1ps
module operational_state_control_test;
    localparam logic [7:0] GEN_ID = {opstate_pkg::DEVICE_ID_VALUE, opstate_pkg::BANK_REV_VALUE};
    logic                  clk;
    logic                  reset_n;
    logic                  clk_en;
    opstate_pkg::reg_req_t req;
    opstate_pkg::reg_rsp_t rsp;
    logic                  done, run, ready, pd_act, ovr, clr, ctl_rst, meas, slow;
    int                    err_total = 0, compares = 0, cycles = 0, clr_cnt = 0, rst_cnt = 0;
    int                    i, c;

    operational_state_control uut (.CLOCK_IN(clk), .RESET_N_IN(reset_n), .CLK_EN_IN(clk_en),
        .REQ_IN(req), .RSP_OUT(rsp), .CONV_DONE_IN(done), .CONV_RUN_OUT(run), .READY_OUT(ready),
        .POWER_DOWN_ACTIVE_OUT(pd_act), .STARTUP_OVERRIDE_OUT(ovr), .CLEAR_RESULTS_OUT(clr),
        .CONTROL_RESET_OUT(ctl_rst), .MEASURING_OUT(meas));
    conv_model conv (.clk_in(clk), .rst_n_in(reset_n), .run_in(run), .slow_in(slow),
        .done_out(done));

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // pulse counters; samples before the edge updates land, so each pulse counts once
    always @(posedge clk)
    begin
        cycles++;
        if (clr === 1'b1) clr_cnt++;
        if (ctl_rst === 1'b1) rst_cnt++;
        if (cycles == 5000)
        begin
            err_total++;
            results();
        end
    end

    task results();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input bit ok, input string what);
        compares++;
        if (!ok)
        begin
            err_total++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    // one access, held for one clock edge; the answer stands at the following negedge
    task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = {w, r, a, d};
        @(negedge clk);
        req = '0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        acc(1'b0, 1'b1, a, 8'h00);
        chk(rsp.rdata === exp, what);
    endtask

    // bounded wait on the ready level
    task wait_ready(input logic lvl);
        for (i = 0; i < 60 && ready !== lvl; i++) @(negedge clk);
        chk(ready === lvl, "ready level");
    endtask

    initial
    begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        req = '0;
        slow = 1'b0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        rd(8'h00, 8'h42, "reset value");
        chk(pd_act === 1'b1 && meas === 1'b0 && ready === 1'b1, "reset outputs");
        rd(8'hf2, GEN_ID, "id with high nibble");
        acc(1'b1, 1'b0, 8'h02, 8'hff);
        rd(8'h02, GEN_ID, "id read only");
        acc(1'b1, 1'b0, 8'h00, 8'h80);
        rd(8'h00, 8'h02, "start ignored in config");
        chk(run === 1'b0, "no run in config");
        acc(1'b1, 1'b0, 8'h00, 8'h03);
        rd(8'h00, 8'h03, "enter measurement");
        acc(1'b1, 1'b0, 8'h00, 8'h80);
        rd(8'h00, 8'h83, "start in measurement");
        wait_ready(1'b0);
        wait_ready(1'b1);
        acc(1'b0, 1'b1, 8'h07, 8'h00);
        chk(rsp.refused === 1'b1, "control refused");
        acc(1'b0, 1'b1, 8'h02, 8'h00);
        chk(rsp.result_sel === 1'b1 && rsp.refused === 1'b0, "result access");
        acc(1'b1, 1'b0, 8'h00, 8'h30);
        rd(8'h00, 8'h03, "stop and reserved");
        acc(1'b1, 1'b0, 8'h00, 8'h07);
        rd(8'h00, 8'h03, "upper nop code");
        // start with power-down set: override during conversion, power-down only in pauses
        // let any conversion left from the earlier start finish first
        wait_ready(1'b1);
        acc(1'b1, 1'b0, 8'h00, 8'hc0);
        wait_ready(1'b0);
        // power-down output is registered from the run level, so it drops one cycle later
        @(negedge clk);
        chk(ovr === 1'b1 && pd_act === 1'b0, "startup override");
        wait_ready(1'b1);
        for (i = 0; i < 10 && pd_act !== 1'b1; i++) @(negedge clk);
        chk(pd_act === 1'b1, "power down in pause");
        wait_ready(1'b0);
        c = clr_cnt;
        acc(1'b1, 1'b0, 8'h00, 8'h42);
        chk(run === 1'b0, "stop on leaving");
        rd(8'h00, 8'h42, "start cleared, pd kept");
        chk(clr_cnt == c + 1, "one clear pulse");
        acc(1'b1, 1'b0, 8'h00, 8'h83);
        wait_ready(1'b0);
        c = rst_cnt;
        acc(1'b1, 1'b0, 8'h00, 8'h0a);
        chk(run === 1'b0 && meas === 1'b0, "soft reset stops");
        rd(8'h00, 8'h42, "soft reset value");
        chk(rst_cnt == c + 1, "one reset pulse");
        // frozen clock enable, then a slow conversion
        slow = 1'b1;
        clk_en = 1'b0;
        acc(1'b1, 1'b0, 8'h00, 8'h83);
        clk_en = 1'b1;
        chk(meas === 1'b0, "disabled edge ignored");
        acc(1'b1, 1'b0, 8'h00, 8'h83);
        wait_ready(1'b0);
        wait_ready(1'b1);
        results();
    end
endmodule
